// ### rtl/nsp_pkg.sv
// Constants, types and register map of the navigation state packet formatter.
// Operation
// - Packet 20 is the system state packet, 100 bytes, read only.
// - System word byte 0, filter word 2, seconds 4, microseconds 8.
// - Body acceleration X, Y, Z at 48, 52, 56; g-force at 60.
// - Angular rates X, Y, Z in rad/s at bytes 76, 80, 84.
// - Position deviations latitude, longitude, height at bytes 88, 92, 96.
// - System status is twelve independent flags, one means present.
// - Failures: system 0, accel 1, gyro 2, pressure 4; bits 5, 14 zero.
// - Over-range 6, 7, 9; temperature 10, 11; log 12; voltage 13; overflow 15.
// - Filter word: init flags 0-3, events 7-8, aiding sources 9-15.
// - Fix type in filter bits 6 to 4, codes 0 to 7.
// - Seconds count whole seconds since the 1970 epoch.
// - Microseconds since last second, always 0 to 999999.
// - Packet 21: 8 bytes, seconds at 0, microseconds at 4.
// - Packet 22: 14 bytes, microseconds, year, year day, six date bytes.
// - Packet 23: 4 bytes, system word at 0, filter word at 2.
`default_nettype none
package nsp_pkg;
    // ----------------------------------------------------------------
    // Packets
    // ----------------------------------------------------------------
    localparam logic [7:0] ID_SYS = 8'h14;
    localparam logic [7:0] ID_TIME = 8'h15;
    localparam logic [7:0] ID_CAL = 8'h16;
    localparam logic [7:0] ID_STAT = 8'h17;
    localparam logic [6:0] LEN_SYS = 7'h64;
    localparam logic [6:0] LEN_TIME = 7'h08;
    localparam logic [6:0] LEN_CAL = 7'h0e;
    localparam logic [6:0] LEN_STAT = 7'h04;
    localparam int PAY_BITS = 800;
    localparam int SS_SYS = 0;
    localparam int SS_FILT = 2;
    localparam int SS_SEC = 4;
    localparam int SS_USEC = 8;
    localparam int SS_ACC = 48;
    localparam int SS_G = 60;
    localparam int SS_RATE = 76;
    localparam int SS_SIG = 88;
    localparam int CAL_YEAR = 4;
    localparam int CAL_DATE = 8;
    // ----------------------------------------------------------------
    // Status word bits
    // ----------------------------------------------------------------
    localparam int B_SYS_FAIL = 0;
    localparam int B_ACC_FAIL = 1;
    localparam int B_GYR_FAIL = 2;
    localparam int B_PRS_FAIL = 4;
    localparam int B_ACC_RNG = 6;
    localparam int B_GYR_RNG = 7;
    localparam int B_PRS_RNG = 9;
    localparam int B_TMP_LO = 10;
    localparam int B_TMP_HI = 11;
    localparam int B_LOG_ERR = 12;
    localparam int B_HV = 13;
    localparam int B_OVF = 15;
    localparam int B_INIT = 0;
    localparam int B_FIX = 4;
    localparam int B_EV1 = 7;
    localparam int B_EV2 = 8;
    localparam int B_AID = 9;
    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
    localparam logic [19:0] USEC_MAX = 20'hf423f;
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATE = 12'h004;
    localparam logic [11:0] REG_SEC = 12'h008;
    localparam logic [11:0] REG_USEC = 12'h00c;
    localparam logic [11:0] REG_SYSW = 12'h010;
    localparam logic [11:0] REG_FILTW = 12'h014;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} nsp_fsm_t;
    typedef struct packed {
        logic psel; logic penable; logic pwrite;
        logic [11:0] paddr; logic [31:0] pwdata;
    } nsp_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata; logic pready; logic pslverr;
    } nsp_apb_rsp_t;
    typedef struct packed {
        logic valid; logic [7:0] data; logic first; logic last; logic [7:0] id;
    } nsp_tx_t;
    typedef struct packed {
        logic sys_fail; logic acc_fail; logic gyr_fail; logic prs_fail;
        logic acc_rng; logic gyr_rng; logic prs_rng; logic tmp_lo;
        logic tmp_hi; logic log_err; logic hv; logic ev1; logic ev2;
    } nsp_pin_t;
    typedef struct packed {
        logic [31:0] acc_x; logic [31:0] acc_y; logic [31:0] acc_z;
        logic [31:0] gforce; logic [31:0] rate_x; logic [31:0] rate_y;
        logic [31:0] rate_z; logic [31:0] sig_lat; logic [31:0] sig_lon;
        logic [31:0] sig_hgt; logic [3:0] init; logic [2:0] fix;
        logic [6:0] aid;
    } nsp_nav_t;
    typedef struct packed {
        logic [15:0] year; logic [15:0] yday; logic [7:0] month;
        logic [7:0] mday; logic [7:0] wday; logic [7:0] hour;
        logic [7:0] minute; logic [7:0] second;
    } nsp_cal_t;
    typedef struct packed {
        logic [15:0] div; logic [19:0] usec; logic [31:0] sec;
    } nsp_tb_t;
endpackage
`default_nettype wire

// ### rtl/nsp_timebase.sv
// Free-running seconds and microseconds counter for the packet formatter.
`default_nettype none
module nsp_timebase
    import nsp_pkg::*;
#(
    parameter int CYC_P = CYC_PER_US
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Seconds load
    input wire logic i_load,
    input wire logic [31:0] i_sec,
    // Time
    output var logic [19:0] o_usec,
    output var logic [31:0] o_sec
);
    nsp_tb_t st;
    nsp_tb_t nx;

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    always_comb
    begin
        nx = st;
        nx.div = st.div + 16'h0001;
        if (st.div == 16'(CYC_P - 1))
        begin
            nx.div = '0;
            if (st.usec >= USEC_MAX)
            begin
                nx.usec = '0;
                nx.sec = st.sec + 32'h0000_0001;
            end
            else
            begin
                nx.usec = st.usec + 20'h00001;
            end
        end
        if (i_load)
        begin
            nx.sec = i_sec;
            nx.usec = '0;
            nx.div = '0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= nx;
    end

    assign o_usec = st.usec;
    assign o_sec = st.sec;
endmodule // nsp_timebase
`default_nettype wire

// ### rtl/nsp_formatter.sv
// Navigation state packet formatter with APB control and a byte stream out.
//
// The register addresses and the APB slave port were chosen for this implementation.
`default_nettype none
module nsp_formatter
    import nsp_pkg::*;
#(
    parameter int CYC_PER_US_P = CYC_PER_US
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Register bus
    input wire nsp_apb_req_t i_apb,
    output var nsp_apb_rsp_t o_apb,
    // Sensor alarm and event pins
    input wire nsp_pin_t i_pins,
    // Navigation engine values
    input wire nsp_nav_t i_nav,
    input wire nsp_cal_t i_cal,
    // Payload byte stream
    input wire logic i_tx_ready,
    output var nsp_tx_t o_tx
);
    typedef struct packed {
        nsp_fsm_t fsm;
        nsp_pin_t pin_s1;
        nsp_pin_t pin_s2;
        logic [1:0] ev;
        logic ovf;
        logic err;
        nsp_tx_t tx;
        logic [6:0] idx;
        logic [7:0] last_id;
        logic [PAY_BITS-1:0] pay;
        nsp_apb_rsp_t rsp;
    } nsp_st_t;

    nsp_st_t st;
    nsp_st_t nx;
    logic [15:0] sys_w;
    logic [15:0] filt_w;
    logic [PAY_BITS-1:0] pay;
    logic [6:0] len;
    logic id_ok;
    logic [7:0] req_id;
    logic setup;
    logic wr;
    logic req;
    logic sec_ld;
    logic mapped;
    logic [31:0] rd;
    logic [19:0] usec;
    logic [31:0] sec;
    logic hs;

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    nsp_timebase #(
        .CYC_P(CYC_PER_US_P)
    ) u_tb (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_load(sec_ld),
        .i_sec(i_apb.pwdata),
        .o_usec(usec),
        .o_sec(sec)
    );

    // ----------------------------------------------------------------
    // Status words
    // ----------------------------------------------------------------
    always_comb
    begin
        sys_w = '0;
        sys_w[B_SYS_FAIL] = st.pin_s2.sys_fail;
        sys_w[B_ACC_FAIL] = st.pin_s2.acc_fail;
        sys_w[B_GYR_FAIL] = st.pin_s2.gyr_fail;
        sys_w[B_PRS_FAIL] = st.pin_s2.prs_fail;
        sys_w[B_ACC_RNG] = st.pin_s2.acc_rng;
        sys_w[B_GYR_RNG] = st.pin_s2.gyr_rng;
        sys_w[B_PRS_RNG] = st.pin_s2.prs_rng;
        sys_w[B_TMP_LO] = st.pin_s2.tmp_lo;
        sys_w[B_TMP_HI] = st.pin_s2.tmp_hi;
        sys_w[B_LOG_ERR] = st.pin_s2.log_err;
        sys_w[B_HV] = st.pin_s2.hv;
        sys_w[B_OVF] = st.ovf;
        filt_w = '0;
        filt_w[B_INIT +: 4] = i_nav.init;
        filt_w[B_FIX +: 3] = i_nav.fix;
        filt_w[B_EV1] = st.ev[0];
        filt_w[B_EV2] = st.ev[1];
        filt_w[B_AID +: 7] = i_nav.aid;
    end

    // ----------------------------------------------------------------
    // Payload assembly
    // ----------------------------------------------------------------
    // Every field lands with its low byte at the lowest offset.
    always_comb
    begin
        pay = '0;
        len = LEN_SYS;
        id_ok = 1'b1;
        req_id = i_apb.pwdata[7:0];
        case (req_id)
            ID_SYS:
            begin
                len = LEN_SYS;
                pay[SS_SYS*8 +: 16] = sys_w;
                pay[SS_FILT*8 +: 16] = filt_w;
                pay[SS_SEC*8 +: 32] = sec;
                pay[SS_USEC*8 +: 32] = {12'h000, usec};
                pay[SS_ACC*8 +: 32] = i_nav.acc_x;
                pay[SS_ACC*8+32 +: 32] = i_nav.acc_y;
                pay[SS_ACC*8+64 +: 32] = i_nav.acc_z;
                pay[SS_G*8 +: 32] = i_nav.gforce;
                pay[SS_RATE*8 +: 32] = i_nav.rate_x;
                pay[SS_RATE*8+32 +: 32] = i_nav.rate_y;
                pay[SS_RATE*8+64 +: 32] = i_nav.rate_z;
                pay[SS_SIG*8 +: 32] = i_nav.sig_lat;
                pay[SS_SIG*8+32 +: 32] = i_nav.sig_lon;
                pay[SS_SIG*8+64 +: 32] = i_nav.sig_hgt;
            end
            ID_TIME:
            begin
                len = LEN_TIME;
                pay[31:0] = sec;
                pay[63:32] = {12'h000, usec};
            end
            ID_CAL:
            begin
                len = LEN_CAL;
                pay[31:0] = {12'h000, usec};
                pay[CAL_YEAR*8 +: 32] = {i_cal.yday, i_cal.year};
                pay[CAL_DATE*8 +: 48] = {i_cal.second, i_cal.minute, i_cal.hour,
                                         i_cal.wday, i_cal.mday, i_cal.month};
            end
            ID_STAT:
            begin
                len = LEN_STAT;
                pay[31:0] = {filt_w, sys_w};
            end
            default:
            begin
                id_ok = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    assign setup = i_apb.psel & ~i_apb.penable;
    assign wr = i_apb.psel & i_apb.penable & st.rsp.pready & i_apb.pwrite;
    assign req = wr && (i_apb.paddr == REG_CTRL);
    assign sec_ld = wr && (i_apb.paddr == REG_SEC);
    assign hs = st.tx.valid & i_tx_ready;

    always_comb
    begin
        mapped = 1'b1;
        rd = '0;
        case (i_apb.paddr)
            REG_CTRL: rd = {24'h000000, st.last_id};
            REG_STATE: rd = {29'h0, st.fsm == ST_SEND, st.err, st.ovf};
            REG_SEC: rd = sec;
            REG_USEC: rd = {12'h000, usec};
            REG_SYSW: rd = {16'h0000, sys_w};
            REG_FILTW: rd = {16'h0000, filt_w};
            default: mapped = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        nx = st;
        nx.pin_s1 = i_pins;
        nx.pin_s2 = st.pin_s1;
        nx.rsp.pready = setup;
        nx.rsp.pslverr = setup & ~mapped;
        nx.rsp.prdata = setup && !i_apb.pwrite ? rd : '0;
        case (st.fsm)
            ST_IDLE:
            begin
                if (req && id_ok)
                begin
                    nx.fsm = ST_SEND;
                    nx.pay = pay;
                    nx.idx = '0;
                    nx.last_id = req_id;
                    nx.err = 1'b0;
                    nx.tx.valid = 1'b1;
                    nx.tx.data = pay[7:0];
                    nx.tx.first = 1'b1;
                    nx.tx.last = 1'b0;
                    nx.tx.id = req_id;
                    if (req_id == ID_SYS || req_id == ID_STAT)
                    begin
                        nx.ev = '0;
                        nx.ovf = 1'b0;
                    end
                end
                else if (req)
                begin
                    nx.err = 1'b1;
                end
            end
            ST_SEND:
            begin
                if (req)
                begin
                    nx.ovf = 1'b1;
                end
                if (hs && st.tx.last)
                begin
                    nx.fsm = ST_IDLE;
                    nx.tx = '0;
                end
                else if (hs)
                begin
                    nx.idx = st.idx + 7'h01;
                    nx.tx.data = st.pay[{nx.idx, 3'b000} +: 8];
                    nx.tx.first = 1'b0;
                    nx.tx.last = (st.idx + 7'h02 == plen(st.tx.id));
                end
            end
            default:
            begin
                nx.fsm = ST_IDLE;
                nx.tx = '0;
            end
        endcase
        // Event flags are sticky; a new event beats the clear of a snapshot.
        if (st.pin_s2.ev1)
            nx.ev[0] = 1'b1;
        if (st.pin_s2.ev2)
            nx.ev[1] = 1'b1;
    end

    function automatic logic [6:0] plen(input logic [7:0] id);
        case (id)
            ID_SYS: plen = LEN_SYS;
            ID_TIME: plen = LEN_TIME;
            ID_CAL: plen = LEN_CAL;
            default: plen = LEN_STAT;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            st <= '0;
            st.fsm <= ST_IDLE;
        end
        else
        begin
            st <= nx;
        end
    end

    assign o_apb = st.rsp;
    assign o_tx = st.tx;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [6:0] cnt;
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n || (st.fsm == ST_IDLE))
            cnt <= '0;
        else if (hs)
            cnt <= cnt + 7'h01;
    end

    property p_sys_len;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        hs && st.tx.last && st.tx.id == ID_SYS |-> cnt == LEN_SYS - 7'h01;
    endproperty
    a_sys_len: assert property (p_sys_len) else $error("system packet length wrong");

    property p_time_len;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        hs && st.tx.last && st.tx.id == ID_TIME |-> cnt == LEN_TIME - 7'h01;
    endproperty
    a_time_len: assert property (p_time_len) else $error("time packet length wrong");

    property p_sys_first;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        st.fsm == ST_IDLE && req && req_id == ID_SYS
        |=> o_tx.valid && o_tx.first && o_tx.data == $past(sys_w[7:0]);
    endproperty
    a_sys_first: assert property (p_sys_first) else $error("first byte not status low");

    property p_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_tx.valid && !i_tx_ready |=> $stable(o_tx);
    endproperty
    a_hold: assert property (p_hold) else $error("stream byte changed while stalled");

    property p_reserved;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        sys_w[5] == 1'b0 && sys_w[14] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved status bit set");

    property p_fix;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        filt_w[6:4] == i_nav.fix;
    endproperty
    a_fix: assert property (p_fix) else $error("fix code misplaced");

    property p_usec_range;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        usec <= USEC_MAX;
    endproperty
    a_usec_range: assert property (p_usec_range) else $error("microseconds out of range");

    property p_wrap;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (usec == USEC_MAX && !sec_ld) ##1 (usec != USEC_MAX)
        |-> usec == 20'h00000 && sec == $past(sec) + 32'h0000_0001;
    endproperty
    a_wrap: assert property (p_wrap) else $error("seconds did not advance");

    property p_ovf;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        st.fsm == ST_SEND && req |=> sys_w[B_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_c_sys;
        @(posedge i_ref_clk) hs && st.tx.last && st.tx.id == ID_SYS;
    endproperty
    c_sys: cover property (p_c_sys);

    property p_c_cal;
        @(posedge i_ref_clk) hs && st.tx.last && st.tx.id == ID_CAL;
    endproperty
    c_cal: cover property (p_c_cal);

    property p_c_stall;
        @(posedge i_ref_clk) o_tx.valid && !i_tx_ready ##1 hs;
    endproperty
    c_stall: cover property (p_c_stall);
endmodule // nsp_formatter
`default_nettype wire

// ### verif/nsp_host_sink.sv
// Host-side model that accepts the payload byte stream, stalling at will.
`default_nettype none
module nsp_host_sink
    import nsp_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Stream and mode
    input wire nsp_tx_t i_tx,
    input wire logic i_slow,
    // Flow control
    output var logic o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_ready = 1'b0;
    // In slow mode a pending byte is refused at random, so holding is exercised.
    always @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_ready <= 1'b0;
        else if (i_slow && i_tx.valid)
            o_ready <= 1'($urandom % 2);
        else
            o_ready <= 1'b1;
    end
endmodule // nsp_host_sink
`default_nettype wire

// ### verif/test_nav_state_packet_formatter.sv
// Self-checking bench for the navigation state packet formatter.
`default_nettype none
module test_nav_state_packet_formatter
    import nsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CYC = 2;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic slow = 1'b0;
    logic ready;
    nsp_apb_req_t apb = '0;
    nsp_apb_rsp_t rsp;
    nsp_pin_t pins = '0;
    nsp_nav_t nav = '0;
    nsp_cal_t cal = '0;
    nsp_tx_t tx;
    int mismatches = 0;
    int num_checks = 0;
    int cyc = 0;
    int t0 = 0;
    int t1 = 0;
    int last_seen = 0;
    logic [7:0] rx[$];
    logic [7:0] ex[$];
    logic [31:0] rd;
    logic [31:0] sec0;
    logic err;
    logic [7:0] cur_id = '0;
    // ----------------------------------------------------------------
    // Design and host model
    // ----------------------------------------------------------------
    nsp_formatter #(.CYC_PER_US_P(CYC)) dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_apb(apb), .o_apb(rsp), .i_pins(pins), .i_nav(nav), .i_cal(cal),
        .i_tx_ready(ready), .o_tx(tx));
    nsp_host_sink host_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tx(tx),
        .i_slow(slow), .o_ready(ready));
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    always @(posedge i_ref_clk)
    begin
        if (tx.valid === 1'b1 && ready === 1'b1)
        begin
            chk("first", tx.first, rx.size() == 0);
            chk("stream id", tx.id, cur_id);
            rx.push_back(tx.data);
            last_seen = (tx.last === 1'b1);
        end
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic final_report();
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_ref_clk);
        apb.penable <= 1'b1;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            mismatches++;
            final_report();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        t1 = cyc;
        apb <= '0;
    endtask
    function automatic logic [15:0] sysw(input logic ov);
        return {ov, 1'b0, pins.hv, pins.log_err, pins.tmp_hi, pins.tmp_lo, pins.prs_rng, 1'b0,
            pins.gyr_rng, pins.acc_rng, 1'b0, pins.prs_fail, 1'b0, pins.gyr_fail,
            pins.acc_fail, pins.sys_fail};
    endfunction
    function automatic logic [15:0] filtw(input logic [1:0] ev);
        return {nav.aid, ev, nav.fix, nav.init};
    endfunction
    task automatic put(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++)
            ex.push_back(v[8*i +: 8]);
    endtask
    task automatic start(input logic [7:0] id);
        rx = {};
        ex = {};
        last_seen = 0;
        cur_id = id;
        bus(1'b1, REG_CTRL, {24'h0, id});
    endtask
    task automatic finish(input logic [7:0] id, input logic [6:0] len, input logic full);
        int n;
        int us;
        logic [31:0] u;
        n = 0;
        us = (t1 - t0) / CYC;
        while (last_seen == 0 && n < 3000)
        begin
            @(posedge i_ref_clk);
            n++;
        end
        if (n >= 3000)
        begin
            mismatches++;
            final_report();
        end
        chk("length", rx.size(), len);
        if (full)
        begin
            n = (id == ID_SYS) ? SS_USEC : (id == ID_TIME) ? 4 : 0;
            u = {rx[n + 3], rx[n + 2], rx[n + 1], rx[n]};
            // The compact status packet carries no time field.
            if (id != ID_STAT)
                chk("usec near", (u <= USEC_MAX) && (u + 1 >= us) && (u <= us + 1), 1);
            if (id == ID_SYS || id == ID_STAT)
                put({filtw(2'b00), sysw(1'b0)}, 4);
            if (id == ID_SYS || id == ID_TIME)
                put(sec0, 4);
            if (id != ID_STAT)
                put(u, 4);
            if (id == ID_SYS)
            begin
                repeat (36) ex.push_back(8'h00);
                put(nav.acc_x, 4);
                put(nav.acc_y, 4);
                put(nav.acc_z, 4);
                put(nav.gforce, 4);
                repeat (12) ex.push_back(8'h00);
                put(nav.rate_x, 4);
                put(nav.rate_y, 4);
                put(nav.rate_z, 4);
                put(nav.sig_lat, 4);
                put(nav.sig_lon, 4);
                put(nav.sig_hgt, 4);
            end
            if (id == ID_CAL)
                put({cal.yday, cal.year}, 4);
            if (id == ID_CAL)
                put({cal.hour, cal.wday, cal.mday, cal.month}, 4);
            if (id == ID_CAL)
                put({cal.second, cal.minute}, 2);
            foreach (ex[i])
                chk("payload byte", rx[i], ex[i]);
        end
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rd = $urandom(826);
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < $bits(nav); i++)
            nav[i] <= 1'($urandom);
        for (int i = 0; i < $bits(cal); i++)
            cal[i] <= 1'($urandom);
        for (int i = 2; i < $bits(pins); i++)
            pins[i] <= 1'($urandom);
        repeat (4) @(posedge i_ref_clk);
        bus(1'b0, REG_SYSW, 0);
        chk("system word", rd, sysw(1'b0));
        for (int f = 0; f < 8; f++)
        begin
            nav.fix <= 3'(f);
            bus(1'b0, REG_FILTW, 0);
            chk("filter word", rd, filtw(2'b00));
        end
        sec0 = $urandom;
        bus(1'b1, REG_SEC, sec0);
        t0 = t1;
        bus(1'b0, REG_SEC, 0);
        chk("seconds", rd, sec0);
        bus(1'b0, REG_USEC, 0);
        chk("usec reg", (rd + 1 >= (t1 - t0) / CYC) &&
            (rd <= (t1 - t0) / CYC + 1), 1);
        for (int k = 0; k < 8; k++)
        begin
            slow <= k[2];
            start(ID_SYS + 8'(k % 4));
            finish(ID_SYS + 8'(k % 4), (k % 4 == 0) ? LEN_SYS : (k % 4 == 1) ? LEN_TIME :
                (k % 4 == 2) ? LEN_CAL : LEN_STAT, 1'b1);
        end
        bus(1'b0, REG_CTRL, 0);
        chk("last id", rd, {24'h0, ID_STAT});
        bus(1'b0, 12'h0fc, 0);
        chk("unmapped error", err, 1);
        chk("unmapped data", rd, 0);
        start(8'h18);
        bus(1'b0, REG_STATE, 0);
        chk("bad id", rd[2:0], 3'b010);
        chk("no stream", rx.size(), 0);
        start(ID_SYS);
        bus(1'b1, REG_CTRL, {24'h0, ID_TIME});
        bus(1'b0, REG_SYSW, 0);
        chk("overflow", rd, sysw(1'b1));
        bus(1'b0, REG_STATE, 0);
        chk("busy overflow", rd[2:0], 3'b101);
        finish(ID_SYS, LEN_SYS, 1'b0);
        pins.ev1 <= 1'b1;
        pins.ev2 <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        pins.ev1 <= 1'b0;
        pins.ev2 <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        bus(1'b0, REG_FILTW, 0);
        chk("events", rd, filtw(2'b11));
        start(ID_STAT);
        finish(ID_STAT, LEN_STAT, 1'b0);
        bus(1'b0, REG_FILTW, 0);
        chk("events clear", rd, filtw(2'b00));
        bus(1'b0, REG_SYSW, 0);
        chk("overflow clear", rd, sysw(1'b0));
        final_report();
    end
endmodule // test_nav_state_packet_formatter
`default_nettype wire
